// [core/sqs_switch_top.sv]
// Control, serial frame checking and fault signalling of a quad low-side switch
// How it works
// - Serial error pin pulled low on parity mismatch or bit count not multiple of 8
// - Fault pin pulled low while any fault exists, released once cleared
// - Faults: thermal shutdown, overload of on channel, reverse current, UVLO, limit pin short
// - Reverse current drives reverse flag low and turns all outputs off
// - Reverse detection works on every channel whether on or off
// - Inrush mode doubles current limit for a window after each turn-on
// - After the window the normal current limit returns
// - Inrush mode follows its select input; open input means disabled
// - Edge select low gives slow edges, up to 50 kHz switching
// - Edge select high gives fast edges, up to 500 kHz switching
// - Daisy chain: serial input shifts through to serial output, eight bits later
// - Kill input low forces all outputs off; high follows last configuration
`timescale 1ns/1ps
module sqs_switch_top
  import sqs_pkg::*;
#(
  parameter int INRUSH_CYC = SQS_INRUSH_CYCLES
)(
  input  wire logic       SYS_CLK,
  input  wire logic       NRST,
  input  wire logic       SCLK,
  input  wire logic       CS_N,
  input  wire logic       SDI,
  output logic            SDO,
  input  wire logic       OUTPUT_KILL_N,
  input  wire logic       INRUSH_SELECT,
  input  wire logic       FAST_EDGE_SELECT,
  input  wire logic       THERMAL_SHUTDOWN,
  input  wire logic [3:0] CH_OVERLOAD,
  input  wire logic [3:0] REV_DETECT,
  input  wire logic       UVLO_5V,
  input  wire logic       CURRENT_LIMIT_SET_PIN_SHORT,
  output logic [3:0]      OUT_ON,
  output logic [3:0]      LIMIT_DOUBLE,
  output logic            SLEW_FAST,
  output logic            REV_N,
  output logic            FAULT_N_OUT,
  output logic            FAULT_N_OE,
  output logic            SERIAL_FRAME_ERROR_N_OUT,
  output logic            SERIAL_FRAME_ERROR_N_OE
);

  // ************************************************
  // Serial frame capture
  // ************************************************
  logic                 sclk_d_ff;
  logic                 cs_n_d_ff;
  logic [7:0]           sh_ff;
  logic [7:0]           nxt_sh;
  logic [SQS_CNT_W-1:0] cnt_ff;
  logic [SQS_CNT_W-1:0] nxt_cnt;
  logic                 any_ff;
  logic                 nxt_any;
  logic                 sdo_ff;
  logic                 nxt_sdo;
  logic [3:0]           cfg_ff;
  logic [3:0]           nxt_cfg;
  logic                 err_ff;
  logic                 nxt_err;
  logic                 sclk_rise;
  logic                 cs_fall;
  logic                 cs_rise;
  logic                 frame_good;
  logic [7:0]           status;

  assign sclk_rise  = SCLK && !sclk_d_ff;
  assign cs_fall    = !CS_N && cs_n_d_ff;
  assign cs_rise    = CS_N && !cs_n_d_ff;
  // Even parity over the last byte; zero clocks is no frame at all
  assign frame_good = any_ff && (cnt_ff == '0) && !(^sh_ff);

  always_comb begin
    nxt_sh  = sh_ff;
    nxt_cnt = cnt_ff;
    nxt_any = any_ff;
    nxt_sdo = sdo_ff;
    nxt_cfg = cfg_ff;
    nxt_err = err_ff;
    if (cs_fall) begin
      nxt_sh  = status;
      nxt_cnt = '0;
      nxt_any = 1'b0;
      nxt_sdo = status[7];
    end else if (!CS_N && sclk_rise) begin
      nxt_sh  = {sh_ff[6:0], SDI};
      nxt_cnt = cnt_ff + SQS_CNT_W'(1);
      nxt_any = 1'b1;
      nxt_sdo = sh_ff[6];
    end
    if (cs_rise && any_ff) begin
      if (frame_good) begin
        nxt_cfg = sh_ff[SQS_CFG_MSB:SQS_CFG_LSB];
        nxt_err = 1'b0;
      end else begin
        nxt_err = 1'b1;
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      sclk_d_ff <= 1'b0;
      cs_n_d_ff <= 1'b1;
      sh_ff     <= SQS_SH_RST;
      cnt_ff    <= '0;
      any_ff    <= 1'b0;
      sdo_ff    <= 1'b0;
      cfg_ff    <= SQS_CFG_RST;
      err_ff    <= 1'b0;
    end else begin
      sclk_d_ff <= SCLK;
      cs_n_d_ff <= CS_N;
      sh_ff     <= nxt_sh;
      cnt_ff    <= nxt_cnt;
      any_ff    <= nxt_any;
      sdo_ff    <= nxt_sdo;
      cfg_ff    <= nxt_cfg;
      err_ff    <= nxt_err;
    end
  end

  // ************************************************
  // Output control and fault gathering
  // ************************************************
  logic [3:0] on_ff;
  logic [3:0] nxt_on;
  logic       rev_ff;
  logic       nxt_rev;
  logic       fault_ff;
  logic       nxt_fault;
  logic       fast_ff;

  assign status = {CH_OVERLOAD, rev_ff, THERMAL_SHUTDOWN, UVLO_5V,
                   CURRENT_LIMIT_SET_PIN_SHORT};

  always_comb begin
    nxt_rev   = |REV_DETECT;
    // Kill and reverse current both override the configuration
    nxt_on    = cfg_ff & {4{OUTPUT_KILL_N}} & {4{!rev_ff}};
    nxt_fault = THERMAL_SHUTDOWN || (|(CH_OVERLOAD & on_ff)) || rev_ff
                || UVLO_5V || CURRENT_LIMIT_SET_PIN_SHORT;
  end

  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      on_ff    <= 4'h0;
      rev_ff   <= 1'b0;
      fault_ff <= 1'b0;
      fast_ff  <= 1'b0;
    end else begin
      on_ff    <= nxt_on;
      rev_ff   <= nxt_rev;
      fault_ff <= nxt_fault;
      fast_ff  <= FAST_EDGE_SELECT;
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < SQS_CHANNELS; ch++) begin : g_inrush
      sqs_inrush_timer #(
        .WIN_CYC (INRUSH_CYC)
      ) u_timer (
        .clk    (SYS_CLK),
        .nrst   (NRST),
        .enable (INRUSH_SELECT),
        .on     (on_ff[ch]),
        .boost  (LIMIT_DOUBLE[ch])
      );
    end
  endgenerate

  // Open-drain pins only ever drive low
  assign SDO                      = sdo_ff;
  assign OUT_ON                   = on_ff;
  assign SLEW_FAST                = fast_ff;
  assign REV_N                    = !rev_ff;
  assign FAULT_N_OUT              = 1'b0;
  assign FAULT_N_OE               = fault_ff;
  assign SERIAL_FRAME_ERROR_N_OUT = 1'b0;
  assign SERIAL_FRAME_ERROR_N_OE  = err_ff;

  // ************************************************
  // Checks
  // ************************************************
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);

  count_err_a: assert property (cs_rise && any_ff && cnt_ff != '0 |=> SERIAL_FRAME_ERROR_N_OE)
    else $error("bad bit count not flagged");
  parity_err_a: assert property (cs_rise && any_ff && (^sh_ff) |=> SERIAL_FRAME_ERROR_N_OE)
    else $error("parity mismatch not flagged");
  cfg_apply_a: assert property (cs_rise && frame_good |=> cfg_ff == $past(sh_ff[7:4]))
    else $error("good frame not applied");
  cfg_hold_a: assert property (cs_rise && !frame_good |=> $stable(cfg_ff))
    else $error("bad frame changed configuration");
  fault_set_a: assert property ($rose(UVLO_5V) |=> FAULT_N_OE)
    else $error("undervoltage did not raise fault");
  fault_clear_a: assert property (!THERMAL_SHUTDOWN && !UVLO_5V && !rev_ff
      && !CURRENT_LIMIT_SET_PIN_SHORT && !(|(CH_OVERLOAD & on_ff)) |=> !FAULT_N_OE)
    else $error("fault pin held after fault cleared");
  rev_off_a: assert property (|REV_DETECT |=> !REV_N ##1 OUT_ON == 4'h0)
    else $error("reverse current did not shut outputs");
  rev_idle_a: assert property (|(REV_DETECT & ~cfg_ff) |=> !REV_N)
    else $error("reverse current missed on off channel");
  kill_a: assert property (!OUTPUT_KILL_N |=> OUT_ON == 4'h0)
    else $error("outputs on while killed");
  follow_a: assert property (OUTPUT_KILL_N && !rev_ff |=> OUT_ON == $past(cfg_ff))
    else $error("outputs do not follow configuration");
  slew_a: assert property (##1 SLEW_FAST == $past(FAST_EDGE_SELECT))
    else $error("edge rate select not followed");

  good_frame_c: cover property (cs_rise && frame_good);
  bad_frame_c: cover property (cs_rise && any_ff && !frame_good);
  rev_trip_c: cover property (OUT_ON != 4'h0 ##1 |REV_DETECT);

endmodule

// [core/sqs_pkg.sv]
// Shared constants of the quad switch control and fault logic
package sqs_pkg;

  // ************************************************
  // Clock and timing
  // ************************************************
  localparam int SQS_CLK_FREQ_HZ      = 40_000_000;
  localparam int SQS_SCLK_MAX_HZ      = 10_000_000;
  localparam int SQS_INRUSH_TIME_US   = 10_000;
  // Least time; whole microseconds at 40 clocks each, so no rounding is applied
  localparam int SQS_INRUSH_CYCLES    =
    (SQS_INRUSH_TIME_US * (SQS_CLK_FREQ_HZ / 1_000_000) + 0) ;
  localparam int SQS_SLOW_SW_MAX_HZ   = 50_000;
  localparam int SQS_FAST_SW_MAX_HZ   = 500_000;

  // ************************************************
  // Serial frame
  // ************************************************
  localparam int SQS_CHANNELS         = 4;
  localparam int SQS_FRAME_BITS       = 8;
  localparam int SQS_CNT_W            = $clog2(SQS_FRAME_BITS);
  localparam int SQS_CFG_MSB          = 7;
  localparam int SQS_CFG_LSB          = 4;
  localparam logic [3:0] SQS_CFG_RST  = 4'h0;
  localparam logic [7:0] SQS_SH_RST   = 8'h00;

endpackage

// [core/sqs_inrush_timer.sv]
// Per-channel inrush window timer that doubles the current limit
`timescale 1ns/1ps
module sqs_inrush_timer
  import sqs_pkg::*;
#(
  parameter int WIN_CYC = SQS_INRUSH_CYCLES
)(
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic enable,
  input  wire logic on,
  output logic      boost
);

  localparam int CW = $clog2(WIN_CYC + 1);
  localparam logic [CW-1:0] WIN_LOAD = CW'(WIN_CYC);

  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] nxt_cnt;
  logic          on_ff;
  logic          boost_ff;
  logic          nxt_boost;

  always_comb begin
    nxt_cnt   = cnt_ff;
    nxt_boost = 1'b0;
    if (!enable || !on) begin
      nxt_cnt = '0;
    end else if (!on_ff) begin
      nxt_cnt   = WIN_LOAD;
      nxt_boost = 1'b1;
    end else if (cnt_ff != '0) begin
      nxt_cnt   = cnt_ff - CW'(1);
      nxt_boost = (cnt_ff != CW'(1));
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cnt_ff   <= '0;
      on_ff    <= 1'b0;
      boost_ff <= 1'b0;
    end else begin
      cnt_ff   <= nxt_cnt;
      on_ff    <= on;
      boost_ff <= nxt_boost;
    end
  end

  assign boost = boost_ff;

  // ************************************************
  // Checks
  // ************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  inrush_start_a: assert property (enable && on && !on_ff |=> boost)
    else $error("inrush window did not open on turn-on");
  inrush_off_a: assert property (!enable |=> !boost)
    else $error("boost while inrush mode disabled");
  inrush_end_a: assert property (boost && cnt_ff == CW'(1) |=> !boost)
    else $error("boost outlived the inrush window");
  inrush_seen_c: cover property (enable && on && !on_ff ##1 boost [*3]);

endmodule

// [bench/sqs_spi_master.sv]
// Serial master model that drives frames into the switch
`timescale 1ns/1ps
module sqs_spi_master (
  input  wire logic clk,
  output logic      sclk,
  output logic      cs_n,
  output logic      sdi,
  input  wire logic sdo
);
  // ********
  // Frames
  // ********
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi  = 1'b0;
  end
  // At least two clocks per half period keeps SCLK at or under 10 MHz
  task automatic xfer(input logic [15:0] d, input int n, output logic [15:0] r);
    r = 16'h0000;
    repeat (3) @(posedge clk);
    #1 cs_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      repeat (2) @(posedge clk);
      #1 sclk = 1'b0;
      sdi = d[i];
      repeat (2) @(posedge clk);
      #1 r = {r[14:0], sdo};
      sclk = 1'b1;
    end
    repeat (2) @(posedge clk);
    #1 sclk = 1'b0;
    // Released line must not show a stale bit
    sdi = ~sdi;
    repeat (2) @(posedge clk);
    #1 cs_n = 1'b1;
  endtask
endmodule

// [bench/tb.sv]
// Self-checking bench of the quad switch control and fault logic
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
  $display("wrong value %s exp %h got %h", nm, e, g); end end
module tb import sqs_pkg::*; ;
  localparam int ICYC = 20;
  // Outputs right after reset: all off, no doubling, both open drains released
  localparam logic [12:0] RST_OUT = {SQS_CFG_RST, 4'h0, 5'b00100};
  logic        clk, nrst, sclk, cs_n, sdi, sdo, kill_n, inr, fe, tsd, uvlo, shrt;
  logic        slew, rev_n, f_out, f_oe, e_out, e_oe;
  logic [3:0]  ovl, rev, out_on, dbl, c, p;
  logic [7:0]  a;
  logic [15:0] r;
  int          n_fail = 0, cmp_count = 0, seed = 32'h415936a0;
  sqs_switch_top #(.INRUSH_CYC(ICYC)) DUT (
    .SYS_CLK                    (clk),
    .NRST                       (nrst),
    .SCLK                       (sclk),
    .CS_N                       (cs_n),
    .SDI                        (sdi),
    .SDO                        (sdo),
    .OUTPUT_KILL_N              (kill_n),
    .INRUSH_SELECT              (inr),
    .FAST_EDGE_SELECT           (fe),
    .THERMAL_SHUTDOWN           (tsd),
    .CH_OVERLOAD                (ovl),
    .REV_DETECT                 (rev),
    .UVLO_5V                    (uvlo),
    .CURRENT_LIMIT_SET_PIN_SHORT(shrt),
    .OUT_ON                     (out_on),
    .LIMIT_DOUBLE               (dbl),
    .SLEW_FAST                  (slew),
    .REV_N                      (rev_n),
    .FAULT_N_OUT                (f_out),
    .FAULT_N_OE                 (f_oe),
    .SERIAL_FRAME_ERROR_N_OUT   (e_out),
    .SERIAL_FRAME_ERROR_N_OE    (e_oe)
  );
  sqs_spi_master M (.clk(clk), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo));
  // ********
  // Helpers
  // ********
  function automatic logic [7:0] mk(input logic [3:0] v);
    return {v, 3'b000, ^v};
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic frame(input logic [15:0] d, input int n);
    M.xfer(d, n, r);
    tick(4);
  endtask
  task automatic test_done;
    $display("mismatches %0d compares %0d", n_fail, cmp_count);
    if (n_fail == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Hang guard
  initial begin
    #1000000;
    n_fail++;
    test_done;
  end
  // ********
  // Scenarios
  // ********
  initial begin
    {nrst, kill_n, inr, fe, tsd, uvlo, shrt} = 7'b0100000;
    ovl = 4'h0;
    rev = 4'h0;
    p = 4'h0;
    tick(16);
    nrst = 1'b1;
    tick(1);
    `CHK("reset", RST_OUT, {out_on, dbl, f_out, e_out, rev_n, f_oe, e_oe})
    inr = 1'b1;
    repeat (6) begin
      c = $random(seed);
      a = $random(seed);
      fe = $random(seed);
      {tsd, uvlo, shrt} = $random(seed);
      frame({a, mk(c)}, 16);
      `CHK("chain", a, r[7:0])
      `CHK("status", {5'h00, tsd, uvlo, shrt}, r[15:8])
      `CHK("out_on", c, out_on)
      `CHK("limit", c & ~p, dbl)
      `CHK("slew", fe, slew)
      kill_n = 1'b0;
      tick(2);
      `CHK("kill", 4'h0, out_on)
      kill_n = 1'b1;
      tick(3);
      `CHK("unkill", c, out_on)
      tick(ICYC + 2);
      `CHK("limit_end", 4'h0, dbl)
      p = c;
    end
    inr = 1'b0;
    {tsd, uvlo, shrt} = 3'b000;
    frame({8'h00, mk(4'h0)}, 8);
    frame({8'h00, mk(4'hf)}, 8);
    `CHK("no_inrush", 4'h0, dbl)
    frame({8'h00, mk(4'h0) ^ 8'h01}, 8);
    `CHK("parity", 5'h1f, {e_oe, out_on})
    frame({8'h00, mk(4'h5)}, 8);
    `CHK("good", 5'h05, {e_oe, out_on})
    frame({8'h00, mk(4'h0)}, 7);
    `CHK("count", 5'h15, {e_oe, out_on})
    frame({8'h00, mk(4'h5)}, 8);
    `CHK("clear", 5'h05, {e_oe, out_on})
    // No clocks at all is no frame: neither error nor apply
    frame(16'h0000, 0);
    `CHK("empty", 5'h05, {e_oe, out_on})
    // Channels 1 and 3 are off, so their overload must not count
    for (int k = 0; k < 7; k++) begin
      {ovl, shrt, uvlo, tsd} = 7'h01 << k;
      tick(2);
      `CHK("fault", k != 4 && k != 6, f_oe)
      {ovl, shrt, uvlo, tsd} = 7'h00;
      tick(2);
      `CHK("fault_gone", 1'b0, f_oe)
    end
    for (int k = 0; k < 4; k++) begin
      rev = 4'h1 << k;
      tick(3);
      `CHK("reverse", 6'h01, {rev_n, out_on, f_oe})
      rev = 4'h0;
      tick(3);
      `CHK("rev_gone", 6'h2a, {rev_n, out_on, f_oe})
    end
    // Reset in mid-run drops the stored configuration
    nrst = 1'b0;
    tick(2);
    nrst = 1'b1;
    tick(1);
    `CHK("rerun", RST_OUT, {out_on, dbl, f_out, e_out, rev_n, f_oe, e_oe})
    test_done;
  end
endmodule
